// ===== design/adc_seq_defs.svh
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
// register byte offsets
`define OFS_CTRL0 12'h000
`define OFS_CTRL1 12'h004
`define OFS_RES_HI 12'h008
`define OFS_RES_LO 12'h00C
`define OFS_IRQ 12'h010
// control zero fields
`define C0_START 7
`define C0_BUSY 6
`define C0_PWR 5
`define C0_FMT 4
`define C0_CHAN_LSB 0
// control one fields
`define C1_SRC_LSB 5
`define C1_REF_LSB 3
`define C1_DIV_LSB 0
// interrupt register fields
`define IRQ_FLAG 0
`define IRQ_CONV_EN 1
`define IRQ_GLOBAL_EN 2
// reset values
`define CTRL0_RST 8'h00
`define CTRL1_RST 8'h00
// timing counts in converter clocks
`define SAMPLE_CYCLES 5'h04
`define CONVERT_CYCLES 5'h0C
`define TOTAL_CYCLES 5'h10
// recommended converter clock period bounds, ns
`define CONV_CLK_MIN_NS 500
`define CONV_CLK_MAX_NS 10000
// source and reference codes
`define SRC_INTERNAL 3'h1
`define REF_SUPPLY 2'h1
`define FULL_SCALE 12'hFFF
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== design/adc_seq_pkg.sv
package adc_seq_pkg;
  // analog core control bundle
  typedef struct packed {
    logic power_on;      // converter powered
    logic hold_reset;    // core held in reset
    logic sample;        // sampling phase
    logic convert;       // conversion phase
    logic sel_internal;  // internal amplified input
    logic sel_ground;    // grounded input
    logic ref_supply;    // reference from supply
    logic [3:0] channel; // external channel
  } core_ctrl_t;
  // sequencer phases
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_SAMPLE,
    ST_CONVERT
  } seq_state_t;
endpackage

// ===== design/conv_clock_divider.sv
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
// makes one-cycle converter clock ticks from the system clock
module conv_clock_divider
  import adc_seq_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic clear_i,     // restart the divider phase
  input wire logic [2:0] sel_i, // divide by 2^sel
  output logic tick_o           // one pulse per converter clock
);
  logic [6:0] cnt_ff; // free count of system clocks
  logic [6:0] nxt_cnt;
  logic [6:0] mask;   // low bits that must be all ones

  // next count and tick; all-ones under mask marks a period end
  always_comb
  begin
    mask = 7'(8'h7F >> (3'h7 - sel_i)) & 7'h7F;
    if (sel_i == 3'h0)
    begin
      mask = 7'h00;
    end
    nxt_cnt = clear_i ? 7'h00 : 7'(cnt_ff + 7'h01);
    tick_o = ~clear_i & ((cnt_ff & mask) == mask);
  end

  // count register
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= 7'h00;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// ===== design/conv_phase_timer.sv
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
// walks the sample and convert phases on converter clock ticks
module conv_phase_timer
  import adc_seq_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic hold_i,  // core held in reset
  input wire logic go_i,    // one-cycle start
  input wire logic tick_i,  // converter clock tick
  output seq_state_t state_o,
  output logic done_o       // one-cycle end of conversion
);
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [4:0] cnt_ff; // converter clocks elapsed in conversion
  logic [4:0] nxt_cnt;

  assign state_o = state_ff;

  // phase sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    done_o = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (go_i)
        begin
          nxt_state = ST_SAMPLE;
          nxt_cnt = 5'h00;
        end
      end
      ST_SAMPLE:
      begin
        if (tick_i)
        begin
          nxt_cnt = 5'(cnt_ff + 5'h01);
          if (nxt_cnt == `SAMPLE_CYCLES)
          begin
            nxt_state = ST_CONVERT;
          end
        end
      end
      ST_CONVERT:
      begin
        if (tick_i)
        begin
          nxt_cnt = 5'(cnt_ff + 5'h01);
          if (nxt_cnt == `TOTAL_CYCLES)
          begin
            nxt_state = ST_IDLE;
            done_o = 1'b1;
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (hold_i)
    begin
      nxt_state = ST_IDLE;
      nxt_cnt = 5'h00;
      done_o = 1'b0;
    end
  end

  // phase registers
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 5'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// ===== design/adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
// converter sequencer with an axi4-lite register slave
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  // axi4-lite write address
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [11:0] awaddr_i,
  // axi4-lite write data
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // axi4-lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // axi4-lite read address
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [11:0] araddr_i,
  // axi4-lite read data
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // analog core
  output adc_seq_pkg::core_ctrl_t core_o,
  input wire logic [11:0] core_result_i, // settled code at end
  // interrupt to the processor
  output logic irq_o
);
  // control and status state
  logic [7:0] ctrl0_ff; // start, power, format, channel
  logic [7:0] ctrl1_ff; // source, reference, divider
  logic flag_ff;        // completion request flag
  logic conv_en_ff;     // converter interrupt enable
  logic glob_en_ff;     // global interrupt enable
  logic busy_ff;        // conversion in progress
  logic [11:0] res_ff;  // captured result
  logic fmt_ff;         // format latched at start
  logic [7:0] nxt_ctrl0;
  logic [7:0] nxt_ctrl1;
  logic nxt_flag;
  logic nxt_conv_en;
  logic nxt_glob_en;
  logic nxt_busy;
  logic [11:0] nxt_res;
  logic nxt_fmt;
  // bus state
  logic aw_ff;          // write address held
  logic w_ff;           // write data held
  logic [11:0] awa_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic nxt_aw;
  logic nxt_w;
  logic [11:0] nxt_awa;
  logic [31:0] nxt_wd;
  logic [3:0] nxt_ws;
  logic nxt_bvalid;
  logic [1:0] nxt_bresp;
  logic nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;
  // internal wires
  logic do_write;       // both halves of a write held
  logic start_fall;     // trigger written from high to low
  logic tick;
  logic done;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic [7:0] wbyte;
  seq_state_t phase;

  // divider restarts with each conversion for clean phase
  conv_clock_divider u_div (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .clear_i(ctrl0_ff[`C0_START]),
    .sel_i(ctrl1_ff[`C1_DIV_LSB +: 3]),
    .tick_o(tick)
  );

  // sample and convert phase timer
  conv_phase_timer u_timer (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    // the falling trigger must win over its own last held cycle
    .hold_i((ctrl0_ff[`C0_START] | ~ctrl0_ff[`C0_PWR]) & ~start_fall),
    .go_i(start_fall),
    .tick_i(tick),
    .state_o(phase),
    .done_o(done)
  );

  assign awready_o = ~aw_ff;
  assign wready_o = ~w_ff;
  assign arready_o = ~rvalid_ff;
  assign bvalid_o = bvalid_ff;
  assign bresp_o = bresp_ff;
  assign rvalid_o = rvalid_ff;
  assign rdata_o = rdata_ff;
  assign rresp_o = rresp_ff;
  assign do_write = aw_ff & w_ff & ~bvalid_ff;
  assign wbyte = wd_ff[7:0];
  assign irq_o = flag_ff & conv_en_ff & glob_en_ff;

  // result arrangement: format 0 high-aligned, 1 low-aligned
  always_comb
  begin
    if (fmt_ff)
    begin
      res_hi = {4'h0, res_ff[11:8]};
      res_lo = res_ff[7:0];
    end
    else
    begin
      res_hi = res_ff[11:4];
      res_lo = {res_ff[3:0], 4'h0};
    end
  end

  // trigger falls when a write clears a set start bit
  assign start_fall = do_write & ws_ff[0] & (awa_ff == `OFS_CTRL0)
    & ctrl0_ff[`C0_START] & ~wbyte[`C0_START]
    & ctrl0_ff[`C0_PWR];

  // analog core controls
  always_comb
  begin
    core_o.power_on = ctrl0_ff[`C0_PWR];
    core_o.hold_reset = ctrl0_ff[`C0_START];
    core_o.sample = (phase == ST_SAMPLE);
    core_o.convert = (phase == ST_CONVERT);
    core_o.sel_internal =
      (ctrl1_ff[`C1_SRC_LSB +: 3] == `SRC_INTERNAL);
    core_o.sel_ground = (ctrl1_ff[`C1_SRC_LSB +: 3] >= 3'h2)
      & (ctrl1_ff[`C1_SRC_LSB +: 3] <= 3'h4);
    core_o.ref_supply =
      (ctrl1_ff[`C1_REF_LSB +: 2] == `REF_SUPPLY);
    core_o.channel = ctrl0_ff[`C0_CHAN_LSB +: 4];
  end

  // register file and conversion status next values
  always_comb
  begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_ctrl1 = ctrl1_ff;
    nxt_flag = flag_ff;
    nxt_conv_en = conv_en_ff;
    nxt_glob_en = glob_en_ff;
    nxt_busy = busy_ff;
    nxt_res = res_ff;
    nxt_fmt = fmt_ff;
    // software writes, low byte lane only
    if (do_write & ws_ff[0])
    begin
      case (awa_ff)
        `OFS_CTRL0:
        begin
          // busy bit is read only
          nxt_ctrl0 = {wbyte[7], 1'b0, wbyte[5:0]};
        end
        `OFS_CTRL1:
        begin
          nxt_ctrl1 = wbyte;
        end
        `OFS_IRQ:
        begin
          if (!wbyte[`IRQ_FLAG])
          begin
            nxt_flag = 1'b0; // writing zero clears the flag
          end
          nxt_conv_en = wbyte[`IRQ_CONV_EN];
          nxt_glob_en = wbyte[`IRQ_GLOBAL_EN];
        end
        default:
        begin
        end
      endcase
    end
    // conversion start: busy rises, format captured
    if (start_fall)
    begin
      nxt_busy = 1'b1;
      nxt_fmt = ctrl0_ff[`C0_FMT];
    end
    // trigger high or power off abandons conversion
    if (ctrl0_ff[`C0_START] | ~ctrl0_ff[`C0_PWR])
    begin
      if (!start_fall)
      begin
        nxt_busy = 1'b0;
      end
    end
    // completion: result stored, busy drops, flag set wins
    if (done)
    begin
      nxt_busy = 1'b0;
      nxt_res = core_result_i & `FULL_SCALE;
      nxt_flag = 1'b1;
    end
  end

  // register file and status registers
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl0_ff <= `CTRL0_RST;
      ctrl1_ff <= `CTRL1_RST;
      flag_ff <= 1'b0;
      conv_en_ff <= 1'b0;
      glob_en_ff <= 1'b0;
      busy_ff <= 1'b0;
      res_ff <= 12'h000;
      fmt_ff <= 1'b0;
    end
    else
    begin
      ctrl0_ff <= nxt_ctrl0;
      ctrl1_ff <= nxt_ctrl1;
      flag_ff <= nxt_flag;
      conv_en_ff <= nxt_conv_en;
      glob_en_ff <= nxt_glob_en;
      busy_ff <= nxt_busy;
      res_ff <= nxt_res;
      fmt_ff <= nxt_fmt;
    end
  end

  // bus channel next values
  always_comb
  begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    // capture address and data in either order
    if (awvalid_i & ~aw_ff)
    begin
      nxt_aw = 1'b1;
      nxt_awa = {awaddr_i[11:2], 2'b00};
    end
    if (wvalid_i & ~w_ff)
    begin
      nxt_w = 1'b1;
      nxt_wd = wdata_i;
      nxt_ws = wstrb_i;
    end
    // write commits and response issues
    if (do_write)
    begin
      nxt_bvalid = 1'b1;
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      case (awa_ff)
        `OFS_CTRL0, `OFS_CTRL1, `OFS_RES_HI, `OFS_RES_LO, `OFS_IRQ:
        begin
          nxt_bresp = `RESP_OKAY;
        end
        default:
        begin
          nxt_bresp = `RESP_SLVERR;
        end
      endcase
    end
    else if (bvalid_ff & bready_i)
    begin
      nxt_bvalid = 1'b0;
    end
    // read answer
    if (arvalid_i & ~rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `RESP_OKAY;
      case ({araddr_i[11:2], 2'b00})
        `OFS_CTRL0:
        begin
          nxt_rdata = {24'h0, ctrl0_ff[7], busy_ff,
            ctrl0_ff[5:0]};
        end
        `OFS_CTRL1:
        begin
          nxt_rdata = {24'h0, ctrl1_ff};
        end
        `OFS_RES_HI:
        begin
          nxt_rdata = {24'h0, res_hi};
        end
        `OFS_RES_LO:
        begin
          nxt_rdata = {24'h0, res_lo};
        end
        `OFS_IRQ:
        begin
          nxt_rdata = {29'h0, glob_en_ff, conv_en_ff, flag_ff};
        end
        default:
        begin
          nxt_rdata = 32'h0;
          nxt_rresp = `RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff & rready_i)
    begin
      nxt_rvalid = 1'b0;
    end
  end

  // bus channel registers
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 12'h000;
      wd_ff <= 32'h0;
      ws_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= 2'h0;
    end
    else
    begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end
endmodule

// ===== dv/adc_seq_chk.sv
`timescale 1ns/1ps
// protocol and phase checks on the sequencer ports
module adc_seq_chk
  import adc_seq_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [1:0] bresp_o,
  input wire adc_seq_pkg::core_ctrl_t core_o
);
  import adc_seq_pkg::*;
  logic [11:0] samp_ff, nxt_samp; // sample cycles, held while converting
  logic [11:0] conv_ff, nxt_conv; // convert cycles so far
  // phase length counters
  always_comb
  begin
    nxt_conv = core_o.convert ? conv_ff + 12'h001 : 12'h000;
    nxt_samp = core_o.convert ? samp_ff : 12'h000;
    if (core_o.sample)
      nxt_samp = samp_ff + 12'h001;
  end
  // register the counters
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      samp_ff <= 12'h000;
      conv_ff <= 12'h000;
    end
    else
    begin
      samp_ff <= nxt_samp;
      conv_ff <= nxt_conv;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  hold_idle_a: assert property (core_o.hold_reset ##1
    core_o.hold_reset |-> !core_o.sample && !core_o.convert)
    else $error("run while held");
  power_idle_a: assert property (!core_o.power_on |=>
    !core_o.sample && !core_o.convert) else $error("run while off");
  start_samp_a: assert property ($fell(core_o.hold_reset) &&
    core_o.power_on && $past(core_o.power_on) |-> ##[1:2] core_o.sample)
    else $error("no sample after start");
  samp_conv_a: assert property ($fell(core_o.sample) &&
    !core_o.hold_reset && core_o.power_on |-> core_o.convert)
    else $error("sample not followed by convert");
  conv_len_a: assert property ($fell(core_o.convert) &&
    !core_o.hold_reset && core_o.power_on |-> conv_ff inside {12'h00C,
    12'h018, 12'h030, 12'h060, 12'h0C0, 12'h180, 12'h300, 12'h600})
    else $error("convert length wrong");
  samp_len_a: assert property ($fell(core_o.convert) &&
    !core_o.hold_reset && core_o.power_on |-> 12'h003 * samp_ff <= conv_ff
    && conv_ff <= 12'h003 * samp_ff + 12'h003)
    else $error("sample length wrong");
  phase_excl_a: assert property (!(core_o.sample && core_o.convert) &&
    !(core_o.sel_internal && core_o.sel_ground)) else $error("overlap");
  rd_answer_a: assert property (arvalid_i && arready_o |=> rvalid_o)
    else $error("late read data");
  rd_hold_a: assert property (rvalid_o && !rready_i |=>
    rvalid_o && $stable(rdata_o)) else $error("read data dropped");
  wr_hold_a: assert property (bvalid_o && !bready_i |=>
    bvalid_o && $stable(bresp_o)) else $error("write answer dropped");
endmodule
bind adc_conversion_sequencer adc_seq_chk i_chk (.clock_i(clock_i),
  .nrst_i(nrst_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
  .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o),
  .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
  .core_o(core_o));

// ===== dv/adc_core_model.sv
`timescale 1ns/1ps
// behavioural analog core: a code only while converting
module adc_core_model
  import adc_seq_pkg::*;
(
  input wire logic clock_i,
  input wire adc_seq_pkg::core_ctrl_t core_i,
  output logic [11:0] result_o
);
  import adc_seq_pkg::*;
  logic [11:0] junk_ff = 12'h5A5; // meaningless value outside conversion
  // flip each cycle so a stale capture shows up
  always @(posedge clock_i)
    junk_ff <= ~junk_ff;
  // settled code while converting
  always_comb
  begin
    if (!core_i.convert)
      result_o = junk_ff;
    else if (core_i.sel_ground)
      result_o = 12'h000;
    else if (core_i.sel_internal)
      result_o = 12'hFFF;
    else
      result_o = {core_i.channel, 8'hC3};
  end
endmodule

// ===== dv/test_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
// drives the sequencer over axi4-lite and checks conversions
module test_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  localparam int SETTLE = 20; // power-up wait, system clocks
  logic clock_i, nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  logic [11:0] awaddr_i, araddr_i, res, code; // addresses, codes
  logic [31:0] wdata_i, rdata_o, d; // bus data
  logic [3:0] wstrb_i; // byte strobes
  logic [1:0] bresp_o, rresp_o, r; // responses
  logic [7:0] c0; // control zero image
  core_ctrl_t core; // analog controls
  int err_total, compares, sc, cc, s_len, c_len, n, i;
  adc_conversion_sequencer i_dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i),
    .wstrb_i(wstrb_i), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .bresp_o(bresp_o), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .araddr_i(araddr_i), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .core_o(core),
    .core_result_i(res), .irq_o(irq_o));
  adc_core_model i_core (.clock_i(clock_i), .core_i(core), .result_o(res));
  // system clock
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // phase lengths of the last run
  always @(posedge clock_i)
  begin
    if (core.sample)
    begin
      sc++;
    end
    else if (sc > 0)
    begin
      s_len = sc;
      sc = 0;
    end
    if (core.convert)
    begin
      cc++;
    end
    else if (cc > 0)
    begin
      c_len = cc;
      cc = 0;
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("errors %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // axi write, response left in r
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr_i <= a;
    wdata_i <= v;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    while (aw || w)
    begin
      @(posedge clock_i);
      if (awready_o)
      begin
        aw = 1'b0;
        awvalid_i <= 1'b0;
      end
      if (wready_o)
      begin
        w = 1'b0;
        wvalid_i <= 1'b0;
      end
    end
    @(posedge clock_i);
    bready_i <= 1'b1;
    do @(posedge clock_i); while (!bvalid_o);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask
  // axi read, result left in d and r
  task automatic rd(input logic [11:0] a);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    do @(posedge clock_i); while (!arready_o);
    arvalid_i <= 1'b0;
    @(posedge clock_i);
    rready_i <= 1'b1;
    do @(posedge clock_i); while (!rvalid_o);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
  endtask
  // poll busy until clear, then check the result bytes
  task automatic finish_conv(input logic fmt);
    n = 0;
    do
    begin
      rd(`OFS_CTRL0);
      n++;
    end
    while (d[6] && n < 1000);
    chk(d[6], 0);
    rd(`OFS_RES_HI);
    chk(d, fmt ? {28'h0, code[11:8]} : {24'h0, code[11:4]});
    rd(`OFS_RES_LO);
    chk(d, fmt ? {24'h0, code[7:0]} : {24'h0, code[3:0], 4'h0});
  endtask
  // watchdog
  initial
  begin
    #3000000;
    err_total++;
    finish_test;
  end
  // main sequence
  initial
  begin
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h00;
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = {24'h0, 32'h0, 4'hF};
    {err_total, compares, sc, cc, s_len, c_len} = 0;
    nrst_i = 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      rd(12'(4 * i));
      chk(d, 0);
    end
    rd(12'h020);
    chk(d, 32'h0);
    chk(r, `RESP_SLVERR);
    wr(12'h020, 32'hFF);
    chk(r, `RESP_SLVERR);
    for (i = 0; i < 8; i++)
    begin
      wr(`OFS_CTRL1, 32'((i << 5) | ((i & 3) << 3)));
      chk(core.sel_internal, i == 1);
      chk(core.sel_ground, i inside {[2:4]});
      chk(core.ref_supply, (i & 3) == 1);
    end
    wr(`OFS_CTRL0, 32'h20);
    chk(r, `RESP_OKAY);
    repeat (SETTLE) @(posedge clock_i);
    for (i = 0; i < 8; i++)
    begin
      wr(`OFS_IRQ, 32'(2 + 4 * (i & 1)));
      chk(irq_o, 0);
      wr(`OFS_CTRL1, 32'(i));
      c0 = 8'(8'h20 + 16 * (i & 1) + i);
      wr(`OFS_CTRL0, {24'h0, c0 | 8'h80});
      chk(core.hold_reset, 1);
      wr(`OFS_CTRL0, {24'h0, c0});
      rd(`OFS_CTRL0);
      chk(d[6], 1);
      code = {4'(i), 8'hC3};
      finish_conv(i[0]);
      chk(c_len, 12 << i);
      chk(s_len >= (4 << i) - 1 && s_len <= (4 << i), 1);
      rd(`OFS_IRQ);
      chk(d[0], 1);
      chk(irq_o, i & 1);
    end
    wr(`OFS_CTRL0, 32'h2F);
    wr(`OFS_CTRL1, 32'h26);
    wr(`OFS_CTRL0, 32'hAF);
    wr(`OFS_CTRL0, 32'h2F);
    repeat (SETTLE) @(posedge clock_i);
    wr(`OFS_CTRL0, 32'hAF);
    rd(`OFS_CTRL0);
    chk({d[6], core.sample, core.convert}, 0);
    wr(`OFS_CTRL0, 32'h2F);
    code = 12'hFFF;
    finish_conv(1'b0);
    chk(c_len, 12 << 6);
    wr(`OFS_CTRL0, 32'h8F);
    wr(`OFS_CTRL0, 32'h0F);
    repeat (SETTLE) @(posedge clock_i);
    chk({core.power_on, core.sample}, 0);
    finish_test;
  end
endmodule
